// >>> eqbc_consts.svh
`ifndef EQBC_CONSTS_SVH
`define EQBC_CONSTS_SVH
// ****************************************
// Widths, lane count, pull defaults and reset values
// ****************************************
`define EQBC_BOOST_W 3
`define EQBC_THRESH_W 4
`define EQBC_AMP_W 2
`define EQBC_LANES 4
`define EQBC_EN_PULL 1'b1
`define EQBC_SRC_PULL 1'b1
`define EQBC_BST_PULL 3'h0
`define EQBC_BOOST_RST 3'h0
`define EQBC_THRESH_RST 4'h0
`define EQBC_AMP_RST 2'h0
`define EQBC_EN_RST 1'b1
`endif

// >>> eqbc_pkg.sv
`include "eqbc_consts.svh"
package eqbc_pkg;
    typedef logic [`EQBC_BOOST_W-1:0] eqbc_boost_t;
    typedef enum logic [0:0] {
        EQBC_STANDBY = 1'b0,
        EQBC_NORMAL = 1'b1
    } eqbc_mode_t;
endpackage : eqbc_pkg

// >>> eqbc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "eqbc_consts.svh"
module eqbc_top
    import eqbc_pkg::*;
#(
    parameter int BOOST_W = `EQBC_BOOST_W,
    parameter int THRESH_W = `EQBC_THRESH_W,
    parameter int AMP_W = `EQBC_AMP_W,
    parameter int LANES = `EQBC_LANES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic global_enable,
    input wire logic global_enable_driven,
    input wire logic boost_source_select,
    input wire logic boost_source_select_driven,
    input wire logic boost_level_pin0,
    input wire logic boost_level_pin1,
    input wire logic boost_level_pin2,
    input wire logic [BOOST_W-1:0] boost_pins_driven,
    input wire logic chip_select,
    input wire logic chip_select_driven,
    input wire logic mgmt_wr_stb,
    input wire logic [BOOST_W-1:0] mgmt_boost,
    input wire logic [AMP_W-1:0] mgmt_amplitude,
    input wire logic mgmt_enable,
    input wire logic [THRESH_W-1:0] mgmt_threshold,
    input wire logic clock_lane_level_above,
    input wire logic [THRESH_W-1:0] clock_lane_amplitude,
    output logic [BOOST_W-1:0] lane_boost_level,
    output logic [AMP_W-1:0] lane_amplitude,
    output logic [THRESH_W-1:0] detect_threshold,
    output logic [LANES-1:0] lane_out_enable,
    output logic device_active,
    output logic clock_lane_detect_out
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Seven single-bit pins, two boost groups and the amplitude word
    localparam int NS = 7 + BOOST_W * 2 + THRESH_W;
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    assign raw = {global_enable, global_enable_driven, boost_source_select,
        boost_source_select_driven, boost_level_pin2, boost_level_pin1, boost_level_pin0,
        boost_pins_driven, chip_select, chip_select_driven, clock_lane_level_above,
        clock_lane_amplitude};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    logic en_s, en_drv_s, src_s, src_drv_s, cs_s, cs_drv_s, cl_above_s;
    logic [BOOST_W-1:0] bst_s, bst_drv_s;
    logic [THRESH_W-1:0] cl_amp_s;
    assign {en_s, en_drv_s, src_s, src_drv_s, bst_s, bst_drv_s, cs_s, cs_drv_s,
        cl_above_s, cl_amp_s} = s2_q;

    // ****************************************
    // Pull defaults for undriven pins
    // ****************************************
    logic en_eff, src_eff, cs_eff;
    logic [BOOST_W-1:0] bst_eff;
    assign en_eff = en_drv_s ? en_s : `EQBC_EN_PULL;
    assign src_eff = src_drv_s ? src_s : `EQBC_SRC_PULL;
    assign bst_eff = (bst_s & bst_drv_s) | (`EQBC_BST_PULL & ~bst_drv_s);
    assign cs_eff = cs_drv_s & cs_s;

    // ****************************************
    // Management register
    // ****************************************
    logic [BOOST_W-1:0] reg_boost_q;
    logic [AMP_W-1:0] reg_amp_q;
    logic reg_en_q;
    logic [THRESH_W-1:0] reg_thresh_q;
    logic wr_ok;
    assign wr_ok = mgmt_wr_stb & cs_eff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_boost_q <= `EQBC_BOOST_RST;
            reg_amp_q <= `EQBC_AMP_RST;
            reg_en_q <= `EQBC_EN_RST;
            reg_thresh_q <= `EQBC_THRESH_RST;
        end else if (wr_ok) begin
            reg_boost_q <= mgmt_boost;
            reg_amp_q <= mgmt_amplitude;
            reg_en_q <= mgmt_enable;
            reg_thresh_q <= mgmt_threshold;
        end
    end

    // ****************************************
    // Lane controls
    // ****************************************
    eqbc_mode_t mode;
    eqbc_boost_t boost_sel;
    assign mode = (en_eff & reg_en_q) ? EQBC_NORMAL : EQBC_STANDBY;
    assign boost_sel = src_eff ? bst_eff : reg_boost_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lane_boost_level <= '0;
            lane_amplitude <= '0;
            detect_threshold <= '0;
            lane_out_enable <= '0;
            device_active <= 1'b0;
        end else begin
            lane_boost_level <= boost_sel;
            lane_amplitude <= reg_amp_q;
            detect_threshold <= reg_thresh_q;
            lane_out_enable <= {LANES{mode == EQBC_NORMAL}};
            device_active <= (mode == EQBC_NORMAL);
        end
    end

    // ****************************************
    // Clock lane detect
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_lane_detect_out <= 1'b0;
        end else begin
            clock_lane_detect_out <= (mode == EQBC_NORMAL) & cl_above_s
                & (cl_amp_s >= reg_thresh_q);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_STANDBY_ALL: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == EQBC_STANDBY) |=> (lane_out_enable == '0))
        else $error("lanes not all off in standby");
    AST_NORMAL_ALL: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == EQBC_NORMAL) |=> (lane_out_enable == {LANES{1'b1}}) && device_active)
        else $error("lanes not all on in normal");
    AST_EN_PULL: assert property (@(posedge clk) disable iff (!rst_n)
        (!en_drv_s && reg_en_q) |=> device_active)
        else $error("undriven enable did not enable");
    AST_PIN_BOOST: assert property (@(posedge clk) disable iff (!rst_n)
        (src_eff) |=> (lane_boost_level == $past(bst_eff)))
        else $error("pin boost not applied");
    AST_REG_BOOST: assert property (@(posedge clk) disable iff (!rst_n)
        (!src_eff) |=> (lane_boost_level == $past(reg_boost_q)))
        else $error("register boost not applied");
    AST_SRC_PULL: assert property (@(posedge clk) disable iff (!rst_n)
        (!src_drv_s) |=> (lane_boost_level == $past(bst_eff)))
        else $error("undriven source select not pin");
    AST_BST_PULL: assert property (@(posedge clk) disable iff (!rst_n)
        (src_eff && bst_drv_s == '0) |=> (lane_boost_level == '0))
        else $error("undriven boost pins not low");
    AST_DETECT: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == EQBC_STANDBY || !cl_above_s) |=> !clock_lane_detect_out)
        else $error("detect high without signal");
    AST_CS_GATE: assert property (@(posedge clk) disable iff (!rst_n)
        (!cs_eff) |=> $stable(reg_thresh_q) && $stable(reg_boost_q))
        else $error("write taken without chip select");
    AST_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        eqbc_apply_seq |-> detect_threshold == $past(mgmt_threshold, 2))
        else $error("threshold write not applied");

    // ****************************************
    // Write sequences
    // ****************************************
    // A taken write lands in the register one edge later
    sequence eqbc_take_seq;
        wr_ok ##1 1'b1;
    endsequence

    // A taken write reaches the outputs two edges later
    sequence eqbc_apply_seq;
        wr_ok ##1 (mode == EQBC_NORMAL) ##1 1'b1;
    endsequence

    // ****************************************
    // Register checks
    // ****************************************
    AST_REG_TAKE: assert property (@(posedge clk) disable iff (!rst_n)
        eqbc_take_seq |-> (reg_boost_q == $past(mgmt_boost)) && (reg_amp_q == $past(mgmt_amplitude))
        && (reg_en_q == $past(mgmt_enable)))
        else $error("register write not taken");

    AST_THRESH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (!wr_ok) |=> $stable(reg_thresh_q))
        else $error("threshold moved without write");

    AST_CS_PULL: assert property (@(posedge clk) disable iff (!rst_n)
        (!cs_drv_s) |-> !wr_ok)
        else $error("write taken with select undriven");

    // ****************************************
    // Output follow checks
    // ****************************************
    AST_AMP_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> (lane_amplitude == $past(reg_amp_q)))
        else $error("amplitude not applied");

    AST_THRESH_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> (detect_threshold == $past(reg_thresh_q)))
        else $error("threshold not applied");

    AST_LEVEL_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> (lane_boost_level == $past(boost_sel)))
        else $error("boost code not applied unchanged");

    AST_SRC_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        (src_drv_s && !src_s) |=> (lane_boost_level == $past(reg_boost_q)))
        else $error("driven low select did not pick register");

    // ****************************************
    // Enable and lane checks
    // ****************************************
    // Lanes must never split: all on or all off
    AST_LANES_TOGETHER: assert property (@(posedge clk) disable iff (!rst_n)
        (lane_out_enable == '0) || (lane_out_enable == {LANES{1'b1}}))
        else $error("lanes enabled apart");

    AST_ACTIVE_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
        device_active == lane_out_enable[0])
        else $error("active flag and lanes disagree");

    AST_PD_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        (!device_active) |-> (lane_out_enable == '0))
        else $error("lane driven while powered down");

    AST_EN_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        (en_drv_s && !en_s) |=> !device_active)
        else $error("driven low enable did not stand by");

    AST_EN_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        (en_drv_s && en_s && reg_en_q) |=> device_active)
        else $error("driven high enable did not run");

    AST_REG_EN_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        (!reg_en_q) |=> !device_active)
        else $error("register disable ignored");

    // ****************************************
    // Detect checks
    // ****************************************
    // Detect must rise in normal mode when level and amplitude both clear the threshold
    AST_DETECT_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        ((mode == EQBC_NORMAL) && cl_above_s && (cl_amp_s >= reg_thresh_q))
        |=> clock_lane_detect_out)
        else $error("detect low with signal");

    AST_DETECT_THRESH: assert property (@(posedge clk) disable iff (!rst_n)
        (cl_amp_s < reg_thresh_q) |=> !clock_lane_detect_out)
        else $error("detect high below threshold");

    // ****************************************
    // Synchroniser check
    // ****************************************
    // Logic reads only the second stage, so it must trail the first by one edge
    AST_SYNC_STAGE: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> (s2_q == $past(s1_q)))
        else $error("synchroniser stage skipped");
endmodule : eqbc_top
`default_nettype wire

// >>> eqbc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Management host on the far side
// ****************************************
module eqbc_host_model (
    input wire logic clk,
    input wire logic req,
    input wire logic [9:0] req_data,
    input wire logic req_cs,
    output logic chip_select,
    output logic mgmt_wr_stb,
    output logic [9:0] mgmt_word
);
    // Select is raised well before any strobe by the caller
    always @(posedge clk) begin
        chip_select <= req_cs;
        mgmt_wr_stb <= req;
        // Data lines hold nothing useful outside a strobe
        mgmt_word <= req ? req_data : ~req_data;
    end
endmodule : eqbc_host_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "eqbc_consts.svh"
module testbench
    import eqbc_pkg::*;
;
    logic clk, rst_n, ge, ged, src, srcd, csr, csd, req, above, cs, stb, act_o, det_o;
    logic [2:0] pins, pd, boost_o;
    logic [1:0] amp_o;
    logic [3:0] amp, thr_o, loe_o;
    logic [9:0] wd, word;
    logic [31:0] r;
    int fail_count, num_checks, seed, mb, ma, me, mt, i, en_e, src_e, pin_e, act_e;
    eqbc_host_model eqbc_host_model_inst (.clk(clk), .req(req), .req_data(wd), .req_cs(csr),
        .chip_select(cs), .mgmt_wr_stb(stb), .mgmt_word(word));
    eqbc_top eqbc_top_inst (.clk(clk), .rst_n(rst_n), .global_enable(ge),
        .global_enable_driven(ged), .boost_source_select(src), .boost_source_select_driven(srcd),
        .boost_level_pin0(pins[0]), .boost_level_pin1(pins[1]), .boost_level_pin2(pins[2]),
        .boost_pins_driven(pd), .chip_select(cs), .chip_select_driven(csd), .mgmt_wr_stb(stb),
        .mgmt_boost(word[2:0]), .mgmt_amplitude(word[4:3]), .mgmt_enable(word[5]),
        .mgmt_threshold(word[9:6]), .clock_lane_level_above(above), .clock_lane_amplitude(amp),
        .lane_boost_level(boost_o), .lane_amplitude(amp_o), .detect_threshold(thr_o),
        .lane_out_enable(loe_o), .device_active(act_o), .clock_lane_detect_out(det_o));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task final_report;
        $display("checks=%0d failures=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task do_reset;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check(loe_o, 4'h0);
        {mb, ma, me, mt} = {32'd0, 32'd0, 32'd1, 32'd0};
        @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    // ****************************************
    // Random pins and writes against the model
    // ****************************************
    initial begin
        {seed, fail_count, num_checks} = {32'hfd1a, 32'd0, 32'd0};
        {rst_n, ge, ged, src, srcd, csr, csd, req, above, pins, pd, amp, wd} = '0;
        do_reset();
        for (i = 0; i < 80; i++) begin
            if (i == 40) do_reset();
            @(posedge clk);
            r = $random(seed);
            {ge, ged, csr, csd, above} <= {r[0], r[1], r[10] | r[11], r[12] | r[13], r[14] | r[15]};
            {src, srcd, amp, wd} <= {r[2] | (i < 8), r[3] | (i < 8), r[19:16], r[29:20]};
            {pins, pd} <= (i < 8) ? {i[2:0], 3'h7} : r[9:4];
            repeat (4) @(posedge clk);
            if (r[30] | r[31]) begin
                req <= 1'b1;
                @(posedge clk);
                req <= 1'b0;
                if (csr & csd) {mb, ma, me, mt} = {29'd0, wd[2:0], 30'd0, wd[4:3], 31'd0, wd[5],
                    28'd0, wd[9:6]};
            end
            repeat (5) @(posedge clk);
            #1;
            en_e = ged ? ge : `EQBC_EN_PULL;
            src_e = srcd ? src : `EQBC_SRC_PULL;
            pin_e = (pins & pd) | (`EQBC_BST_PULL & ~pd);
            act_e = en_e & me;
            check(boost_o, src_e ? pin_e : mb);
            check(loe_o, act_e ? 4'hf : 4'h0);
            check(act_o, act_e ? EQBC_NORMAL : EQBC_STANDBY);
            check(amp_o, ma);
            check(thr_o, mt);
            check(det_o, act_e & above & (amp >= mt));
        end
        final_report();
    end
endmodule : testbench
`default_nettype wire
